//--- shared/i2c_flags_pkg.sv
// Constants for the serial bus status flag block: register map, field
// positions, reset values and state encodings.
// Assumes one AHB-Lite slave port with 32-bit data and word registers.
package i2c_flags_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_BUS_STATUS_FLAGS = 8'h04;
  localparam logic [7:0] OFF_OWN_ADDRESS = 8'h08;
  localparam logic [7:0] OFF_TX_BUFFER = 8'h0c;
  localparam logic [7:0] OFF_RX_BUFFER = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // Control register fields.
  localparam int CTL_DIRECTION_SELECT = 0;
  localparam int CTL_ACK_JUDGE_ENABLE = 1;
  localparam int CTL_MASTER_MODE = 2;
  localparam int CTL_SYNC_FORMAT = 3;
  localparam int CTL_TX_END_IRQ_EN = 4;
  localparam int CTL_WIDTH = 5;

  // Flag vector positions; the vector sits at bits 7..3 of the status word.
  localparam int FLAG_TX_BUFFER_EMPTY_FLAG = 4;
  localparam int FLAG_TX_END_FLAG = 3;
  localparam int FLAG_RX_BUFFER_FULL_FLAG = 2;
  localparam int FLAG_NACK = 1;
  localparam int FLAG_STOP = 0;
  localparam int FLAG_COUNT = 5;
  localparam int FLAG_LSB = 3;

  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [CTL_WIDTH-1:0] CONTROL_RESET = 5'h00;
  localparam logic [6:0] OWN_ADDRESS_RESET = 7'h00;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

  // Serial frame timing in clock rises of the serial clock.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_RISE = 4'h9;

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_ADDR = 2'b01,
    LINK_DATA = 2'b10
  } link_state_t;

endpackage : i2c_flags_pkg

//--- design/i2c_status_flag_logic.sv
// Status flag logic of the serial bus interface, with its AHB-Lite slave,
// link pin samplers, frame counter, address compare and interrupt logic.
// Assumes SCL_I and SDA_I come from pins in another clock domain and that
// the shift engine signals its events as one-cycle pulses on CLK_SYS_I.
`timescale 1ns/1ps

module i2c_status_flag_logic (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Serial bus pins, sampled only
  input wire logic SCL_I,
  input wire logic SDA_I,
  // Shift engine events
  input wire logic TX_LOAD_I,
  input wire logic START_ISSUED_I,
  input wire logic LAST_BIT_SENT_I,
  input wire logic RX_LOAD_I,
  input wire logic [7:0] RX_DATA_I,
  // Outputs to the shift engine and the system
  output logic [7:0] TX_DATA_O,
  output logic TX_HALT_O,
  output logic TX_END_IRQ_O,
  output logic IRQ_O
);
  import i2c_flags_pkg::*;

  // Bus address phase capture.
  logic [7:0] addr_q_r;
  logic wr_q_r;
  logic ahb_take;
  logic [31:0] rdata_nxt;

  // Software visible state.
  logic [CTL_WIDTH-1:0] control_r;
  logic [6:0] own_address_r;
  logic [7:0] tx_buffer_r;
  logic [7:0] rx_buffer_r;
  logic [FLAG_COUNT-1:0] flags_r;
  logic [FLAG_COUNT-1:0] flags_nxt;
  logic [FLAG_COUNT-1:0] armed_r;
  logic [FLAG_COUNT-1:0] irq_status_r;
  logic [FLAG_COUNT-1:0] irq_mask_r;
  logic [FLAG_COUNT-1:0] set_vec;
  logic [FLAG_COUNT-1:0] clr_vec;
  logic [FLAG_COUNT-1:0] wr0_clr;

  // Decoded accesses.
  logic wr_control;
  logic wr_status;
  logic wr_txbuf;
  logic rd_rxbuf;
  logic rd_status;
  logic rd_irq_status;

  // Link samplers and frame tracking.
  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r;
  logic scl_rise, start_cond, stop_cond, nine_rise, byte_done;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] byte_in;
  link_state_t link_state_r;
  logic addr_match_r;
  logic slave_xmit_r;
  logic frame_done_r;
  logic addr_hit;
  logic to_xmit;
  logic transmitting;
  logic dir_rise;

  function automatic logic is_access(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : is_access

  // Bus slave: zero wait states, every answer OKAY.
  assign ahb_take = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ);

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      addr_q_r <= 8'h00;
      wr_q_r <= 1'b0;
    end else begin
      addr_q_r <= HADDR_I[7:0];
      wr_q_r <= ahb_take && HWRITE_I;
    end
  end

  assign wr_control = wr_q_r && is_access(addr_q_r, OFF_CONTROL);
  assign wr_status = wr_q_r && is_access(addr_q_r, OFF_BUS_STATUS_FLAGS);
  assign wr_txbuf = wr_q_r && is_access(addr_q_r, OFF_TX_BUFFER);
  assign rd_status = ahb_take && !HWRITE_I && is_access(HADDR_I[7:0], OFF_BUS_STATUS_FLAGS);
  assign rd_rxbuf = ahb_take && !HWRITE_I && is_access(HADDR_I[7:0], OFF_RX_BUFFER);
  assign rd_irq_status = ahb_take && !HWRITE_I && is_access(HADDR_I[7:0], OFF_IRQ_STATUS);

  // Read data is captured at the address phase so it stands in the data phase.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (HADDR_I[7:0])
      OFF_CONTROL: rdata_nxt[CTL_WIDTH-1:0] = control_r;
      OFF_BUS_STATUS_FLAGS: rdata_nxt[FLAG_LSB +: FLAG_COUNT] = flags_r;
      OFF_OWN_ADDRESS: rdata_nxt[6:0] = own_address_r;
      OFF_TX_BUFFER: rdata_nxt[7:0] = tx_buffer_r;
      OFF_RX_BUFFER: rdata_nxt[7:0] = rx_buffer_r;
      OFF_IRQ_STATUS: rdata_nxt[FLAG_COUNT-1:0] = irq_status_r;
      OFF_IRQ_MASK: rdata_nxt[FLAG_COUNT-1:0] = irq_mask_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      HRDATA_O <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= HRESP_OKAY;
    end else begin
      HRDATA_O <= (ahb_take && !HWRITE_I) ? rdata_nxt : 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= HRESP_OKAY;
    end
  end

  // Plain software registers.
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      control_r <= CONTROL_RESET;
      own_address_r <= OWN_ADDRESS_RESET;
      tx_buffer_r <= 8'h00;
      irq_mask_r <= 5'h00;
    end else begin
      if (wr_control)
        control_r <= HWDATA_I[CTL_WIDTH-1:0];
      if (wr_q_r && is_access(addr_q_r, OFF_OWN_ADDRESS))
        own_address_r <= HWDATA_I[6:0];
      if (wr_txbuf)
        tx_buffer_r <= HWDATA_I[7:0];
      if (wr_q_r && is_access(addr_q_r, OFF_IRQ_MASK))
        irq_mask_r <= HWDATA_I[FLAG_COUNT-1:0];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I)
      rx_buffer_r <= 8'h00;
    else if (RX_LOAD_I)
      rx_buffer_r <= RX_DATA_I;
  end

  // Two flip-flops per pin, a third stage only for edge finding.
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
    end else begin
      scl_s1_r <= SCL_I;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= SDA_I;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  assign scl_rise = scl_s2_r && !scl_s3_r;
  assign start_cond = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
  assign stop_cond = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;
  assign nine_rise = scl_rise && (bit_cnt_r == ACK_RISE - 4'h1);
  assign byte_done = scl_rise && (bit_cnt_r == BITS_PER_BYTE - 4'h1);
  assign byte_in = {shift_r[6:0], sda_s2_r};
  assign addr_hit = (byte_in[7:1] == own_address_r) || (byte_in[7:1] == GENERAL_CALL_ADDR);

  // Counts serial clock rises within a frame; a start restarts the count.
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
    end else if (start_cond) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise) begin
      bit_cnt_r <= (bit_cnt_r == ACK_RISE) ? 4'h1 : bit_cnt_r + 4'h1;
      if (bit_cnt_r < BITS_PER_BYTE)
        shift_r <= byte_in;
    end
  end

  // Address phase tracking for slave mode and frame tracking for master mode.
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      link_state_r <= LINK_IDLE;
      addr_match_r <= 1'b0;
      slave_xmit_r <= 1'b0;
      frame_done_r <= 1'b0;
    end else if (start_cond) begin
      link_state_r <= LINK_ADDR;
      addr_match_r <= 1'b0;
      slave_xmit_r <= 1'b0;
      frame_done_r <= 1'b0;
    end else if (stop_cond) begin
      link_state_r <= LINK_IDLE;
      addr_match_r <= 1'b0;
      slave_xmit_r <= 1'b0;
      frame_done_r <= 1'b0;
    end else begin
      case (link_state_r)
        LINK_ADDR: begin
          if (byte_done) begin
            link_state_r <= LINK_DATA;
            if (!control_r[CTL_MASTER_MODE] && addr_hit) begin
              addr_match_r <= 1'b1;
              // General call is always a write, so it never turns the slave round.
              slave_xmit_r <= byte_in[0] && (byte_in[7:1] != GENERAL_CALL_ADDR);
            end
          end
        end
        LINK_DATA: begin
          if (nine_rise)
            frame_done_r <= 1'b1;
        end
        LINK_IDLE: link_state_r <= LINK_IDLE;
        default: link_state_r <= LINK_IDLE;
      endcase
    end
  end

  assign to_xmit = (link_state_r == LINK_ADDR) && byte_done && !control_r[CTL_MASTER_MODE]
    && addr_hit && byte_in[0] && (byte_in[7:1] != GENERAL_CALL_ADDR) && !slave_xmit_r;
  assign transmitting = control_r[CTL_MASTER_MODE] ? control_r[CTL_DIRECTION_SELECT]
    : slave_xmit_r;
  assign dir_rise = wr_control && HWDATA_I[CTL_DIRECTION_SELECT]
    && !control_r[CTL_DIRECTION_SELECT];

  // Flag set and clear terms; a set in the same cycle as a clear wins.
  always_comb begin
    set_vec = 5'h00;
    set_vec[FLAG_TX_BUFFER_EMPTY_FLAG] = TX_LOAD_I || dir_rise
      || START_ISSUED_I
      || to_xmit;
    set_vec[FLAG_TX_END_FLAG] = (!control_r[CTL_SYNC_FORMAT] && nine_rise && flags_r[FLAG_TX_BUFFER_EMPTY_FLAG])
      || (control_r[CTL_SYNC_FORMAT] && LAST_BIT_SENT_I);
    set_vec[FLAG_RX_BUFFER_FULL_FLAG] = RX_LOAD_I;
    set_vec[FLAG_NACK] = nine_rise && transmitting && sda_s2_r
      && control_r[CTL_ACK_JUDGE_ENABLE];
    set_vec[FLAG_STOP] = stop_cond && (control_r[CTL_MASTER_MODE] ? frame_done_r
      : addr_match_r);
  end

  // Only bits written 0 that were armed by an earlier read as 1 are cleared.
  assign wr0_clr = wr_status ? (armed_r & ~HWDATA_I[FLAG_LSB +: FLAG_COUNT]) : 5'h00;

  always_comb begin
    clr_vec = wr0_clr;
    if (wr_txbuf) begin
      clr_vec[FLAG_TX_BUFFER_EMPTY_FLAG] = 1'b1;
      clr_vec[FLAG_TX_END_FLAG] = 1'b1;
    end
    if (rd_rxbuf)
      clr_vec[FLAG_RX_BUFFER_FULL_FLAG] = 1'b1;
  end

  assign flags_nxt = (flags_r & ~clr_vec) | set_vec;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I)
      flags_r <= FLAGS_RESET;
    else
      flags_r <= flags_nxt;
  end

  // A read arms the bits it saw as 1; a write to the register disarms, unless a read of it arrives in the same cycle.
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I)
      armed_r <= 5'h00;
    else if (rd_status)
      armed_r <= flags_r;
    else if (wr_status)
      armed_r <= 5'h00;
  end

  // Event status is sticky and cleared by its own read; a new event wins.
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I)
      irq_status_r <= 5'h00;
    else
      irq_status_r <= (rd_irq_status ? 5'h00 : irq_status_r) | set_vec;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      IRQ_O <= 1'b0;
      TX_END_IRQ_O <= 1'b0;
      TX_DATA_O <= 8'h00;
    end else begin
      IRQ_O <= |(irq_status_r & irq_mask_r);
      TX_END_IRQ_O <= flags_r[FLAG_TX_END_FLAG] && control_r[CTL_TX_END_IRQ_EN];
      TX_DATA_O <= tx_buffer_r;
    end
  end

  // Halt holds until the next start so software can decide to stop or resend.
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I)
      TX_HALT_O <= 1'b0;
    else if (start_cond || START_ISSUED_I)
      TX_HALT_O <= 1'b0;
    else if (set_vec[FLAG_NACK])
      TX_HALT_O <= 1'b1;
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);

  a_tx_buffer_empty_flag_on_load:
    assert property (TX_LOAD_I |=> flags_r[FLAG_TX_BUFFER_EMPTY_FLAG])
      else $error("tx empty flag not set after buffer load");
  a_tx_buffer_empty_flag_on_start:
    assert property (START_ISSUED_I |=> flags_r[FLAG_TX_BUFFER_EMPTY_FLAG])
      else $error("tx empty flag not set after start issued");
  a_tx_buffer_empty_flag_slave_turn:
    assert property (to_xmit |=> flags_r[FLAG_TX_BUFFER_EMPTY_FLAG] && slave_xmit_r)
      else $error("tx empty flag not set on slave turn to transmit");
  a_wr0_clears:
    assert property (wr_status |=> (flags_r & $past(wr0_clr & ~set_vec)) == 5'h00)
      else $error("armed flag not cleared by write of zero");
  a_txbuf_clears:
    assert property (wr_txbuf && !set_vec[FLAG_TX_BUFFER_EMPTY_FLAG] && !set_vec[FLAG_TX_END_FLAG]
      |=> !flags_r[FLAG_TX_BUFFER_EMPTY_FLAG] && !flags_r[FLAG_TX_END_FLAG])
      else $error("tx buffer write did not clear flags");
  a_tx_end_flag_ninth:
    assert property (nine_rise && !control_r[CTL_SYNC_FORMAT] && flags_r[FLAG_TX_BUFFER_EMPTY_FLAG]
      |=> flags_r[FLAG_TX_END_FLAG] ##1 TX_END_IRQ_O == $past(control_r[CTL_TX_END_IRQ_EN]))
      else $error("tx end not set on ninth rise");
  a_tx_end_flag_sync:
    assert property (control_r[CTL_SYNC_FORMAT] && LAST_BIT_SENT_I |=> flags_r[FLAG_TX_END_FLAG])
      else $error("tx end not set after last bit");
  a_rx_buffer_full_flag_set:
    assert property (RX_LOAD_I |=> flags_r[FLAG_RX_BUFFER_FULL_FLAG] && rx_buffer_r == $past(RX_DATA_I))
      else $error("rx full flag or buffer not updated");
  a_rx_buffer_full_flag_read:
    assert property (rd_rxbuf && !RX_LOAD_I |=> !flags_r[FLAG_RX_BUFFER_FULL_FLAG])
      else $error("rx buffer read did not clear rx full");
  a_nack_judged:
    assert property ($rose(flags_r[FLAG_NACK]) |-> $past(control_r[CTL_ACK_JUDGE_ENABLE]))
      else $error("no ack flag set with judgement off");
  a_stop_master:
    assert property (stop_cond && control_r[CTL_MASTER_MODE] && frame_done_r
      |=> flags_r[FLAG_STOP])
      else $error("stop flag not set in master mode");
  a_stop_slave:
    assert property ($rose(flags_r[FLAG_STOP]) && !control_r[CTL_MASTER_MODE]
      |-> $past(addr_match_r))
      else $error("stop flag set without address match");
  a_tei_level:
    assert property (TX_END_IRQ_O == $past(flags_r[FLAG_TX_END_FLAG] && control_r[CTL_TX_END_IRQ_EN]))
      else $error("tx end request does not follow flag and enable");
  a_halt_nack:
    assert property (set_vec[FLAG_NACK] && !start_cond && !START_ISSUED_I |=> TX_HALT_O)
      else $error("transfer not halted on missing acknowledge");
  a_write_one_keeps:
    assert property (wr_status && !rd_rxbuf |=> (($past(flags_r) & ~flags_r)
      & ~$past(armed_r & ~HWDATA_I[FLAG_LSB +: FLAG_COUNT])) == 5'h00)
      else $error("flag cleared by write of one or unarmed write");

  c_tx_end_flag_ninth: cover property (nine_rise && flags_r[FLAG_TX_BUFFER_EMPTY_FLAG]);
  c_stop_slave: cover property (set_vec[FLAG_STOP] && !control_r[CTL_MASTER_MODE]);
  c_nack_halt: cover property (set_vec[FLAG_NACK] ##1 TX_HALT_O);
  c_irq_out: cover property (IRQ_O);

endmodule : i2c_status_flag_logic

//--- testbench/i2c_peer_model.sv
// Serial bus peer: drives the clock and data lines for whole frames.
// Assumes both lines carry pull-ups, so a released line reads high.
`timescale 1ns/1ps
module i2c_peer_model (
  // Bus lines
  output logic scl_o,
  output logic sda_o
);
  localparam time HALF = 400ns;

  // The clock stands high between frames, and data is released to its pull-up.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // The odd lead-in keeps the frame out of phase with the system clock.
  task automatic start_cond;
    #37ns;
    sda_o = 1'b0;
    #HALF scl_o = 1'b0;
  endtask : start_cond

  // Data changes only while the clock is low, so no false start or stop appears.
  task automatic send_byte(input logic [7:0] b, input logic ack);
    logic [8:0] bits;
    bits = {b, ack};
    for (int i = 8; i >= 0; i--) begin
      sda_o = bits[i];
      #HALF scl_o = 1'b1;
      #HALF scl_o = 1'b0;
    end
  endtask : send_byte

  task automatic stop_cond;
    sda_o = 1'b0;
    #HALF scl_o = 1'b1;
    #HALF sda_o = 1'b1;
    #HALF;
  endtask : stop_cond
endmodule : i2c_peer_model

//--- testbench/test_i2c_status_flag_logic.sv
// Self-checking bench for the status flag block: table of flag events first,
// then bus frames, clear side effects and the interrupt path.
// Assumes the peer model in its own file and the flag package.
`timescale 1ns/1ps
module test_i2c_status_flag_logic;
  import i2c_flags_pkg::*;
  typedef struct {logic [4:0] ctl; logic [3:0] ev; logic [31:0] exp;} row_t;
  typedef struct {logic [7:0] adr; logic [31:0] exp; logic [31:0] msk;} srow_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] ev = 4'h0;
  logic [7:0] rx_data = 8'h00;
  logic [31:0] rd;
  wire logic [31:0] hrdata;
  wire logic [7:0] tx_data;
  wire logic hreadyout, hresp, scl, sda, tx_halt, tx_end_irq, irq;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  // Event bits: 0 byte to shifter, 1 start issued, 2 last bit out, 3 byte received.
  row_t rows[5] = '{'{5'h00, 4'h1, 32'h80}, '{5'h00, 4'h2, 32'h80}, '{5'h00, 4'h8, 32'h20},
                    '{5'h08, 4'h4, 32'h40}, '{5'h01, 4'h0, 32'h80}};
  srow_t srows[4] = '{'{8'h54, 32'h08, 32'h08}, '{8'h66, 32'h00, 32'h08},
                      '{8'h00, 32'h08, 32'h08}, '{8'h55, 32'h80, 32'h80}};

  i2c_peer_model peer (.scl_o(scl), .sda_o(sda));

  i2c_status_flag_logic dut (
    .CLK_SYS_I(clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hreadyout),
    .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .SCL_I(scl), .SDA_I(sda),
    .TX_LOAD_I(ev[0]), .START_ISSUED_I(ev[1]), .LAST_BIT_SENT_I(ev[2]), .RX_LOAD_I(ev[3]),
    .RX_DATA_I(rx_data), .TX_DATA_O(tx_data), .TX_HALT_O(tx_halt), .TX_END_IRQ_O(tx_end_irq),
    .IRQ_O(irq)
  );

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks

  // One single transfer; read data is taken at the edge that ends the data phase.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk,
                        input string msg);
    ahb(1'b0, a, 32'h0);
    chk(rd & msk, exp, msg);
  endtask : rd_chk

  task automatic clear_flags;
    ahb(1'b0, OFF_BUS_STATUS_FLAGS, 32'h0);
    ahb(1'b1, OFF_BUS_STATUS_FLAGS, 32'h0);
  endtask : clear_flags

  task automatic pulse(input logic [3:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 4'h0;
    ticks(2);
  endtask : pulse

  task automatic frame(input logic [7:0] b, input logic ack);
    peer.start_cond();
    peer.send_byte(b, ack);
    peer.stop_cond();
    ticks(8);
  endtask : frame

  initial begin
    ticks(16);
    srst <= 1'b0;
    rd_chk(OFF_BUS_STATUS_FLAGS, 32'h0, '1, "status after reset");
    chk({28'h0, hreadyout, hresp, tx_halt, irq}, 32'h8, "outputs after reset");
    rd_chk(8'h1c, 32'h0, '1, "unmapped read");
    foreach (rows[i]) begin
      ahb(1'b1, OFF_CONTROL, {27'h0, rows[i].ctl});
      if (rows[i].ev != 4'h0) begin
        pulse(rows[i].ev);
      end
      ticks(2);
      rd_chk(OFF_BUS_STATUS_FLAGS, rows[i].exp, '1, "flag set");
      clear_flags();
      rd_chk(OFF_BUS_STATUS_FLAGS, 32'h0, '1, "flag clear");
    end
    // Master transmit with a missing acknowledge, judgement on.
    ahb(1'b1, OFF_CONTROL, 32'h0);
    ahb(1'b1, OFF_CONTROL, 32'h17);
    frame(8'h96, 1'b1);
    rd_chk(OFF_BUS_STATUS_FLAGS, 32'hd8, '1, "master frame");
    chk({31'h0, tx_halt}, 32'h1, "halt on no-ack");
    chk({31'h0, tx_end_irq}, 32'h1, "end request");
    clear_flags();
    ticks(2);
    chk({31'h0, tx_end_irq}, 32'h0, "end request withdrawn");
    rd_chk(OFF_BUS_STATUS_FLAGS, 32'h0, '1, "master flags cleared");
    ahb(1'b1, OFF_CONTROL, 32'h15);
    frame(8'h96, 1'b1);
    rd_chk(OFF_BUS_STATUS_FLAGS, 32'h0, 32'h10, "no-ack ignored");
    chk({31'h0, tx_halt}, 32'h0, "no halt");
    // Slave: own, other, general call and own-read addresses.
    ahb(1'b1, OFF_CONTROL, 32'h0);
    ahb(1'b1, OFF_OWN_ADDRESS, 32'h2a);
    foreach (srows[i]) begin
      clear_flags();
      frame(srows[i].adr, 1'b0);
      rd_chk(OFF_BUS_STATUS_FLAGS, srows[i].exp, srows[i].msk, "slave frame");
    end
    clear_flags();
    ahb(1'b1, OFF_CONTROL, 32'h08);
    pulse(4'h5);
    rd_chk(OFF_BUS_STATUS_FLAGS, 32'hc0, '1, "empty and end");
    ahb(1'b1, OFF_TX_BUFFER, 32'ha5);
    rd_chk(OFF_BUS_STATUS_FLAGS, 32'h0, '1, "buffer write clears");
    chk({24'h0, tx_data}, 32'ha5, "tx data");
    rx_data <= 8'h3c;
    pulse(4'h8);
    rd_chk(OFF_RX_BUFFER, 32'h3c, '1, "rx data");
    rd_chk(OFF_BUS_STATUS_FLAGS, 32'h0, '1, "rx read clears");
    // Writes without a prior read, and writes of one, leave the flag set.
    pulse(4'h1);
    ahb(1'b1, OFF_BUS_STATUS_FLAGS, 32'h0);
    rd_chk(OFF_BUS_STATUS_FLAGS, 32'h80, '1, "unarmed clear");
    ahb(1'b1, OFF_BUS_STATUS_FLAGS, 32'hf8);
    ahb(1'b1, OFF_BUS_STATUS_FLAGS, 32'h0);
    rd_chk(OFF_BUS_STATUS_FLAGS, 32'h80, '1, "write of one");
    clear_flags();
    // Interrupt raised, cleared by reading its status, then masked.
    ahb(1'b0, OFF_IRQ_STATUS, 32'h0);
    ahb(1'b1, OFF_IRQ_MASK, 32'h10);
    pulse(4'h1);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd_chk(OFF_IRQ_STATUS, 32'h10, '1, "irq status");
    ticks(3);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    ahb(1'b1, OFF_IRQ_MASK, 32'h0);
    pulse(4'h1);
    chk({31'h0, irq}, 32'h0, "irq masked");
    // A reset in mid-run must drop flags that are standing.
    pulse(4'h5);
    srst <= 1'b1;
    ticks(2);
    srst <= 1'b0;
    rd_chk(OFF_BUS_STATUS_FLAGS, 32'h0, '1, "status after second reset");
    chk({31'h0, tx_end_irq}, 32'h0, "end request after second reset");
    finish_test();
  end
endmodule : test_i2c_status_flag_logic
